// ---- design/boot_mode_reset_select.sv ----
// Overview of operation
// RQ1 - strap 10 boots EPROM, select drives chip select
// RQ2 - straps 001 select host processor boot
// RQ3 - straps 011 select link port boot
// RQ4 - straps 000 run from external memory
// RQ5 - board never applies 010 or 11x
// RQ6 - one instruction fetched per clock cycle
// RQ7 - clock source runs continuously at rate
// RQ8 - reset restarts fetch at reset vector
// RQ9 - processor reset held low during power-up
// RQ10 - test reset forces scan machine to reset
// RQ11 - test reset pulsed or held low
// RQ12 - scan logic steps on test clock
// RQ13 - scan chain output shifts onto data out
// RQ14 - emulator holds test reset until started
// RQ15 - only bus master drives boot select
// RQ16 - boot select drivable only in EPROM mode
// RQ17 - straps sampled during reset, mode held
// RQ18 - after reset, start path of decoded mode
`timescale 1ns/1ns
module boot_mode_reset_select
   import boot_mode_pkg::*;
#(
   parameter int BOOT_BYTES = EPROM_BOOT_BYTES,
   parameter int SCAN_BITS = SCAN_LEN
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic core_reset_n_in,
   input wire logic eprom_boot_strap_in,
   input wire logic link_boot_strap_in,
   input wire logic boot_memory_select_n_in,
   output logic boot_memory_select_n_out,
   output logic boot_memory_select_n_oe_out,
   input wire logic bus_master_in,
   input wire logic [7:0] eprom_data_in,
   output logic [EPROM_ADDR_W-1:0] eprom_addr_out,
   output logic [7:0] boot_byte_out,
   output logic boot_byte_valid_out,
   output logic host_boot_req_out,
   output logic link_boot_req_out,
   input wire logic boot_done_in,
   output logic [ADDR_W-1:0] fetch_addr_out,
   output logic fetch_valid_out,
   output logic fetch_external_out,
   output logic [2:0] boot_mode_out,
   output logic reserved_mode_out,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic trst_n_in,
   output logic tdo_out,
   output logic tap_reset_out,
   output logic emulation_status_n_out,
   output logic emulation_status_n_oe_out,
   output logic reserved_output_out
);
   // parameters the logic cannot serve stop elaboration
   if (BOOT_BYTES < 1 || BOOT_BYTES > (1 << EPROM_ADDR_W)) begin : g_bytes
      $error("boot_mode_reset_select: BOOT_BYTES out of range");
   end
   if (SCAN_BITS < 5) begin : g_scan
      $error("boot_mode_reset_select: SCAN_BITS must be at least 5");
   end

   localparam logic [EPROM_ADDR_W-1:0] LAST_BYTE =
      EPROM_ADDR_W'(BOOT_BYTES - 1);

   boot_mode_type mode_q;
   boot_mode_type mode_dec;
   seq_state_type seq_q;
   logic [EPROM_ADDR_W-1:0] eprom_addr_q;
   logic [ADDR_W-1:0] fetch_addr_q;
   logic [7:0] boot_byte_q;
   logic boot_byte_valid_q;
   logic select_oe_q;
   logic select_n_q;
   logic host_req_q;
   logic link_req_q;
   logic external_q;
   logic reserved_q;
   logic [SCAN_BITS-1:0] scan_capture;

   always_comb begin
      mode_dec = mode_reserved; // RQ5
      case ({eprom_boot_strap_in, link_boot_strap_in,
             boot_memory_select_n_in})
         3'h4, 3'h5: mode_dec = mode_eprom; // RQ1
         3'h1: mode_dec = mode_host; // RQ2
         3'h3: mode_dec = mode_link; // RQ3
         3'h0: mode_dec = mode_none; // RQ4
         default: mode_dec = mode_reserved;
      endcase
   end

   // straps are wired, so sampling every reset cycle is harmless and the
   // last sample before release wins
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) mode_q <= MODE_RESET;
      else if (!core_reset_n_in) mode_q <= mode_dec; // RQ17
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) reserved_q <= (MODE_RESET == mode_reserved);
      else if (!core_reset_n_in) reserved_q <= (mode_dec == mode_reserved);
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) seq_q <= seq_reset;
      else if (!core_reset_n_in) seq_q <= seq_reset; // RQ8
      else begin
         case (seq_q)
            seq_reset: begin
               case (mode_q) // RQ18
                  mode_eprom: seq_q <= seq_eprom_load;
                  mode_host, mode_link: seq_q <= seq_wait_load;
                  mode_none: seq_q <= seq_run;
                  default: seq_q <= seq_halt;
               endcase
            end
            seq_eprom_load: begin
               if (eprom_addr_q == LAST_BYTE) seq_q <= seq_run;
            end
            seq_wait_load: begin
               if (boot_done_in) seq_q <= seq_run;
            end
            seq_run: seq_q <= seq_run;
            seq_halt: seq_q <= seq_halt;
            default: seq_q <= seq_reset;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) eprom_addr_q <= EPROM_ADDR_RESET;
      else if (seq_q == seq_eprom_load) eprom_addr_q <= eprom_addr_q + 1'b1;
      else eprom_addr_q <= EPROM_ADDR_RESET;
   end

   // byte read at the address of the previous cycle
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boot_byte_q <= 8'h00;
         boot_byte_valid_q <= 1'b0;
      end else begin
         boot_byte_q <= eprom_data_in;
         boot_byte_valid_q <= (seq_q == seq_eprom_load) && core_reset_n_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) fetch_addr_q <= RESET_VECTOR_ADDR;
      else if (seq_q != seq_run) fetch_addr_q <= RESET_VECTOR_ADDR; // RQ8
      else fetch_addr_q <= fetch_addr_q + 1'b1; // RQ6
   end

   // a non-master in EPROM mode floats the pin so the master owns it
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) select_oe_q <= 1'b0;
      else select_oe_q <= core_reset_n_in && (mode_q == mode_eprom) // RQ16
                          && bus_master_in; // RQ15
   end

   // chip select from a flop so the EPROM never sees a decode glitch
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) select_n_q <= 1'b1;
      else if (!core_reset_n_in) select_n_q <= 1'b1;
      else if (seq_q == seq_reset)
         select_n_q <= (mode_q != mode_eprom); // RQ1
      else if (seq_q == seq_eprom_load)
         select_n_q <= (eprom_addr_q == LAST_BYTE);
   end

   // requests stay up until the loader reports done
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         host_req_q <= 1'b0;
         link_req_q <= 1'b0;
      end else if (!core_reset_n_in
                   || (seq_q == seq_wait_load && boot_done_in)) begin
         host_req_q <= 1'b0;
         link_req_q <= 1'b0;
      end else if (seq_q == seq_reset) begin
         host_req_q <= (mode_q == mode_host); // RQ2
         link_req_q <= (mode_q == mode_link); // RQ3
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) external_q <= 1'b0;
      else if (!core_reset_n_in) external_q <= 1'b0;
      else if (seq_q == seq_reset)
         external_q <= (mode_q == mode_none); // RQ4
   end

   assign boot_memory_select_n_oe_out = select_oe_q;
   assign boot_memory_select_n_out = select_n_q;
   assign eprom_addr_out = eprom_addr_q;
   assign boot_byte_out = boot_byte_q;
   assign boot_byte_valid_out = boot_byte_valid_q;
   assign host_boot_req_out = host_req_q;
   assign link_boot_req_out = link_req_q;
   assign fetch_addr_out = fetch_addr_q;
   assign fetch_valid_out = (seq_q == seq_run);
   assign fetch_external_out = external_q;
   assign boot_mode_out = mode_q;
   assign reserved_mode_out = reserved_q;
   assign emulation_status_n_out = 1'b0;
   assign emulation_status_n_oe_out = 1'b0;
   assign reserved_output_out = 1'b0;

   assign scan_capture = SCAN_BITS'({bus_master_in,
                          boot_memory_select_n_in, link_boot_strap_in,
                          eprom_boot_strap_in, core_reset_n_in});

   scan_tap #(
      .LEN(SCAN_BITS)
   ) u_tap (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .tck_in(tck_in),
      .tms_in(tms_in),
      .tdi_in(tdi_in),
      .trst_n_in(trst_n_in),
      .capture_in(scan_capture),
      .tdo_out(tdo_out),
      .tap_reset_out(tap_reset_out)
   );
endmodule : boot_mode_reset_select

// ---- design/boot_mode_pkg.sv ----
package boot_mode_pkg;
   // decoded strap combinations
   typedef enum logic [2:0] {
      mode_none,
      mode_host,
      mode_link,
      mode_eprom,
      mode_reserved
   } boot_mode_type;

   typedef enum logic [2:0] {
      seq_reset,
      seq_eprom_load,
      seq_wait_load,
      seq_run,
      seq_halt
   } seq_state_type;

   typedef enum logic [3:0] {
      tap_logic_reset,
      tap_run_idle,
      tap_sel_dr,
      tap_cap_dr,
      tap_shift_dr,
      tap_exit1_dr,
      tap_pause_dr,
      tap_exit2_dr,
      tap_upd_dr,
      tap_sel_ir,
      tap_cap_ir,
      tap_shift_ir,
      tap_exit1_ir,
      tap_pause_ir,
      tap_exit2_ir,
      tap_upd_ir
   } tap_state_type;

   localparam int CLK_FREQ_MHZ = 25;
   localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
   localparam int ADDR_W = 32;
   localparam int EPROM_ADDR_W = 16;
   localparam int EPROM_BOOT_BYTES = 256;
   localparam int SCAN_LEN = 8;
   localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 32'h0000_0100;
   localparam logic [EPROM_ADDR_W-1:0] EPROM_ADDR_RESET = 16'h0000;
   localparam boot_mode_type MODE_RESET = mode_none;
endpackage : boot_mode_pkg

// ---- design/scan_tap.sv ----
`timescale 1ns/1ns
module scan_tap
   import boot_mode_pkg::*;
#(
   parameter int LEN = SCAN_LEN
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic trst_n_in,
   input wire logic [LEN-1:0] capture_in,
   output logic tdo_out,
   output logic tap_reset_out
);
   // the shift path needs two bits to have a slice to move
   if (LEN < 2) begin : g_len
      $error("scan_tap: LEN must be at least 2");
   end

   tap_state_type state_q;
   tap_state_type state_d;
   logic tck_q;
   logic tck_rise;
   logic tck_fall;
   logic [LEN-1:0] chain_q;
   logic bypass_q;

   // tck is taken as a plain sampled input, so it must run well below sys_clk
   assign tck_rise = tck_in & ~tck_q;
   assign tck_fall = ~tck_in & tck_q;
   assign tap_reset_out = (state_q == tap_logic_reset);

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) tck_q <= 1'b0;
      else tck_q <= tck_in;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         tap_logic_reset: state_d = tms_in ? tap_logic_reset : tap_run_idle;
         tap_run_idle: state_d = tms_in ? tap_sel_dr : tap_run_idle;
         tap_sel_dr: state_d = tms_in ? tap_sel_ir : tap_cap_dr;
         tap_cap_dr: state_d = tms_in ? tap_exit1_dr : tap_shift_dr;
         tap_shift_dr: state_d = tms_in ? tap_exit1_dr : tap_shift_dr;
         tap_exit1_dr: state_d = tms_in ? tap_upd_dr : tap_pause_dr;
         tap_pause_dr: state_d = tms_in ? tap_exit2_dr : tap_pause_dr;
         tap_exit2_dr: state_d = tms_in ? tap_upd_dr : tap_shift_dr;
         tap_upd_dr: state_d = tms_in ? tap_sel_dr : tap_run_idle;
         tap_sel_ir: state_d = tms_in ? tap_logic_reset : tap_cap_ir;
         tap_cap_ir: state_d = tms_in ? tap_exit1_ir : tap_shift_ir;
         tap_shift_ir: state_d = tms_in ? tap_exit1_ir : tap_shift_ir;
         tap_exit1_ir: state_d = tms_in ? tap_upd_ir : tap_pause_ir;
         tap_pause_ir: state_d = tms_in ? tap_exit2_ir : tap_pause_ir;
         tap_exit2_ir: state_d = tms_in ? tap_upd_ir : tap_shift_ir;
         tap_upd_ir: state_d = tms_in ? tap_sel_dr : tap_run_idle;
         default: state_d = tap_logic_reset;
      endcase
   end

   // test reset acts every sys_clk cycle, whether tck moves or not
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) state_q <= tap_logic_reset;
      else if (!trst_n_in) state_q <= tap_logic_reset; // RQ10
      else if (tck_rise) state_q <= state_d; // RQ12
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chain_q <= '0;
         bypass_q <= 1'b0;
      end else if (tck_rise) begin
         if (state_q == tap_cap_dr) chain_q <= capture_in;
         else if (state_q == tap_shift_dr) chain_q <= {tdi_in, chain_q[LEN-1:1]};
         if (state_q == tap_shift_ir) bypass_q <= tdi_in;
      end
   end

   // tdo changes on the falling tck edge so the far side samples it stable
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) tdo_out <= 1'b0;
      else if (tck_fall) begin
         if (state_q == tap_shift_dr) tdo_out <= chain_q[0]; // RQ13
         else if (state_q == tap_shift_ir) tdo_out <= bypass_q;
      end
   end
endmodule : scan_tap

// ---- tb/boot_mode_asserts.sv ----
`timescale 1ns/1ns
module boot_mode_asserts
   import boot_mode_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic core_reset_n_in,
   input wire logic eprom_boot_strap_in,
   input wire logic link_boot_strap_in,
   input wire logic boot_memory_select_n_in,
   input wire logic boot_memory_select_n_out,
   input wire logic boot_memory_select_n_oe_out,
   input wire logic bus_master_in,
   input wire logic [ADDR_W-1:0] fetch_addr_out,
   input wire logic fetch_valid_out,
   input wire logic [2:0] boot_mode_out,
   input wire logic reserved_mode_out,
   input wire logic trst_n_in,
   input wire logic tap_reset_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire logic [2:0] s = {eprom_boot_strap_in, link_boot_strap_in,
      boot_memory_select_n_in};
   wire logic rs = !core_reset_n_in;
   chk_mode_eprom: assert property (
      rs && s[2:1] == 2'h2 |=> boot_mode_out == 3'h3) else $error("eprom");
   chk_mode_host: assert property (
      rs && s == 3'h1 |=> boot_mode_out == 3'h1) else $error("host");
   chk_mode_link: assert property (
      rs && s == 3'h3 |=> boot_mode_out == 3'h2) else $error("link");
   chk_mode_none: assert property (
      rs && s == 3'h0 |=> boot_mode_out == 3'h0) else $error("none");
   chk_mode_held: assert property (
      core_reset_n_in && $past(core_reset_n_in) |-> $stable(boot_mode_out))
      else $error("mode moved outside reset");
   chk_oe_owner: assert property (
      boot_memory_select_n_oe_out |-> $past(bus_master_in) &&
      boot_mode_out == 3'h3) else $error("select driven wrongly");
   chk_fetch_vector: assert property (
      $rose(fetch_valid_out) |-> fetch_addr_out == RESET_VECTOR_ADDR)
      else $error("fetch not at vector");
   chk_fetch_step: assert property (
      fetch_valid_out && $past(fetch_valid_out) |->
      fetch_addr_out == $past(fetch_addr_out) + 1) else $error("step");
   chk_tap_reset: assert property (
      !trst_n_in |=> tap_reset_out) else $error("tap not reset");
   cover property (boot_mode_out == 3'h3 && !boot_memory_select_n_out);
   cover property ($rose(fetch_valid_out));
   cover property (reserved_mode_out);
endmodule : boot_mode_asserts
bind boot_mode_reset_select boot_mode_asserts boot_mode_asserts_i (
   .sys_clk_in, .arst_n_in, .core_reset_n_in, .eprom_boot_strap_in,
   .link_boot_strap_in, .boot_memory_select_n_in, .boot_memory_select_n_out,
   .boot_memory_select_n_oe_out, .bus_master_in, .fetch_addr_out,
   .fetch_valid_out, .boot_mode_out, .reserved_mode_out, .trst_n_in,
   .tap_reset_out);

// ---- tb/board_model.sv ----
`timescale 1ns/1ns
module board_model (
   input wire logic sys_clk_in,
   input wire logic [15:0] addr_in,
   input wire logic select_n_in,
   input wire logic boot_req_in,
   output logic [7:0] data_out,
   output logic boot_done_out
);
   logic [7:0] last_q = 8'h00;
   logic [1:0] wait_q = 2'h0;
   // deselected eprom floats: show inverse so a stale byte never matches
   assign data_out = select_n_in ? ~last_q : addr_in[7:0] ^ 8'h5A;
   always @(posedge sys_clk_in) begin
      last_q <= data_out;
      wait_q <= boot_req_in ? wait_q + 2'h1 : 2'h0;
      boot_done_out <= boot_req_in && wait_q == 2'h2;
   end
endmodule : board_model

// ---- tb/boot_mode_reset_select_bench.sv ----
`timescale 1ns/1ns
module boot_mode_reset_select_bench;
   import boot_mode_pkg::*;
   localparam int NB = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic core_n = 1'b0;
   logic eb = 1'b0, lb = 1'b0, bs = 1'b0, bm = 1'b1;
   logic tck = 1'b0, tms = 1'b1, tdi = 1'b0;
   logic trst_n = 1'b0;
   logic sel_n, oe, bbv, hreq, lreq, done, fv, fx, rsv, tdo, tapr;
   logic es, eso, ro;
   logic [15:0] ea;
   logic [7:0] ed, bb;
   logic [31:0] fa;
   logic [2:0] md;
   wire logic pin = oe ? sel_n : bs;
   int num_errors = 0, total_checks = 0, cyc = 0;
   int seed = 32'hA11C;
   always #20 clk = ~clk;
   boot_mode_reset_select #(.BOOT_BYTES(NB)) boot_mode_reset_select_i (
      .sys_clk_in(clk), .arst_n_in(rst_n), .core_reset_n_in(core_n),
      .eprom_boot_strap_in(eb), .link_boot_strap_in(lb),
      .boot_memory_select_n_in(pin), .boot_memory_select_n_out(sel_n),
      .boot_memory_select_n_oe_out(oe), .bus_master_in(bm),
      .eprom_data_in(ed), .eprom_addr_out(ea), .boot_byte_out(bb),
      .boot_byte_valid_out(bbv), .host_boot_req_out(hreq),
      .link_boot_req_out(lreq), .boot_done_in(done), .fetch_addr_out(fa),
      .fetch_valid_out(fv), .fetch_external_out(fx), .boot_mode_out(md),
      .reserved_mode_out(rsv), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .trst_n_in(trst_n), .tdo_out(tdo), .tap_reset_out(tapr),
      .emulation_status_n_out(es), .emulation_status_n_oe_out(eso),
      .reserved_output_out(ro));
   board_model board_model_i (.sys_clk_in(clk), .addr_in(ea),
      .select_n_in(sel_n), .boot_req_in(hreq | lreq), .data_out(ed),
      .boot_done_out(done));
   task give_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : check
   function logic [2:0] exp_mode(input logic e, l, b);
      if (e)
         return l ? 3'h4 : 3'h3;
      if (l)
         return b ? 3'h2 : 3'h4;
      return b ? 3'h1 : 3'h0;
   endfunction : exp_mode
   // reserved codes are applied on purpose to see the halt
   task boot(input logic [2:0] s);
      logic [2:0] m;
      int k, n, nv;
      logic o, h, l;
      m = exp_mode(s[2], s[1], s[0]);
      {o, h, l} = 3'h0;
      n = 0;
      nv = 0;
      core_n = 1'b0;
      {eb, lb, bs} = s;
      // both owner cases of the EPROM select are forced once
      bm = (s == 3'h4) ? 1'b1 : (s == 3'h5) ? 1'b0 : 1'($random(seed));
      repeat (3) @(negedge clk);
      core_n = 1'b1;
      for (k = 0; k < 60 && fv !== 1'b1; k++) begin
         @(negedge clk);
         n += (sel_n === 1'b0);
         o |= (oe === 1'b1);
         h |= (hreq === 1'b1);
         l |= (lreq === 1'b1);
         if (bbv === 1'b1) begin
            check("boot byte", 8'(nv) ^ 8'h5A, bb);
            nv++;
         end
      end
      check("mode", m, md);
      check("select cycles", m == 3'h3 ? NB : 0, n);
      check("drive", m == 3'h3 && bm, o);
      check("host req", m == 3'h1, h);
      check("link req", m == 3'h2, l);
      check("run", m != 3'h4, fv);
      check("external", m == 3'h0, fx);
      check("boot bytes", m == 3'h3 ? NB : 0, nv);
      check("vector", RESET_VECTOR_ADDR, fa);
      {eb, lb, bs} = 3'($random(seed));
      repeat (3) @(negedge clk);
      check("mode held", m, md);
      check("fetch step", RESET_VECTOR_ADDR + (m != 3'h4 ? 3 : 0), fa);
      $display("boot test %b done", s);
   endtask : boot
   task step(input logic m);
      tms = m;
      tdi = 1'($random(seed));
      repeat (3) @(negedge clk);
      tck = 1'b1;
      repeat (3) @(negedge clk);
      tck = 1'b0;
      repeat (3) @(negedge clk);
   endtask : step
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++)
         boot(3'(i));
      repeat (4) boot(3'($random(seed)));
      check("tap held", 1'b1, tapr);
      trst_n = 1'b1;
      step(1'b0);
      step(1'b1);
      step(1'b0);
      step(1'b0);
      check("tap left", 1'b0, tapr);
      check("tdo bit0", core_n, tdo);
      step(1'b0);
      check("tdo bit1", eb, tdo);
      trst_n = 1'b0;
      repeat (2) @(negedge clk);
      check("tap reset", 1'b1, tapr);
      $display("scan test done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      check("reset mode", MODE_RESET, md);
      check("reset vector", RESET_VECTOR_ADDR, fa);
      // run, drive, select, tap, spare pins
      check("reset outputs", 7'h18, {fv, oe, sel_n, tapr, es, eso, ro});
      rst_n = 1'b1;
      boot(3'h0);
      give_verdict();
   end
endmodule : boot_mode_reset_select_bench
